// ---- core/iwp_ctrl.sv ----
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module iwp_ctrl import iwp_pkg::*; #(
	parameter int RESTART_CYCLES = RESTART_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_EXT-1:0] extPins,
	input wire iwp_cpu_cmd_t cpuCmd,
	input wire iwp_per_req_t perReq,
	output logic irqRequest,
	output logic [15:0] vectorAddr,
	output logic intMask,
	output logic cpuHold,
	output logic oscEnable,
	output logic cpuTick,
	output logic watchdogResetReq,
	output logic [4:0] daOpenDrain
);
	iwp_state_t s_reg;
	iwp_state_t s_next;
	logic [NUM_EXT-1:0] edgeSeen;
	logic [NUM_EXT-1:0] extFlag;
	logic [NUM_EXT-1:0] extEn;
	logic [NUM_REQ-1:0] reqLine;
	logic anyReq;
	logic wakeHalt;
	logic [15:0] hitVec;
	logic tick;
	logic wrEn;
	logic setupRd;
	logic [2:0] divLast;
	logic restartDone;

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irqRequest = s_reg.irqRequest;
	assign vectorAddr = s_reg.vectorAddr;
	assign intMask = s_reg.iMask;
	assign cpuHold = s_reg.cpuHold;
	assign oscEnable = s_reg.oscEnable;
	assign cpuTick = s_reg.cpuTick;
	assign watchdogResetReq = s_reg.watchdogResetReq;
	assign daOpenDrain = s_reg.daOpenDrain;

	always_comb begin
		// source 3 catches rising edges, the others falling edges
		for (int k = 0; k < NUM_EXT; k++) begin
			if (k == SRC_RISE) begin
				edgeSeen[k] = ~s_reg.pinPrev[k] & s_reg.pinSync2[k];
			end else begin
				edgeSeen[k] = s_reg.pinPrev[k] & ~s_reg.pinSync2[k];
			end
		end
		for (int k = 0; k < SRC_PC2; k++) begin
			extFlag[k] = s_reg.edgeReg[EDGE_FLAG_TOP-k];
			extEn[k] = s_reg.edgeReg[EDGE_EN_TOP-k];
		end
		extFlag[SRC_PC2] = s_reg.misc[MISC_PC2_FLAG];
		extEn[SRC_PC2] = s_reg.misc[MISC_PC2_EN];

		reqLine = '0;
		reqLine[REQ_USB_RESUME] = perReq.usbEndSuspend;
		reqLine[REQ_EXT3] = extFlag[3] & extEn[3];
		reqLine[REQ_EXT2] = extFlag[2] & extEn[2];
		reqLine[REQ_EXT1] = extFlag[1] & extEn[1];
		reqLine[REQ_EXT0] = extFlag[0] & extEn[0];
		reqLine[REQ_EXT4] = extFlag[4] & extEn[4];
		reqLine[REQ_TIM_CAP] = perReq.timerCapture;
		reqLine[REQ_TIM_CMP] = perReq.timerCompare;
		reqLine[REQ_TIM_OVF] = perReq.timerOverflow;
		reqLine[REQ_I2C] = perReq.i2cIrq;
		reqLine[REQ_SCI] = |(perReq.sciFlags & perReq.sciEnables);
		reqLine[REQ_USB] = |(perReq.usbFlags & perReq.usbEnables);
		anyReq = |reqLine;
		wakeHalt = |(reqLine & HALT_WAKE);

		// walk from the last slot down to slot 0 so the lowest-numbered pending slot wins
		hitVec = VEC_RESET;
		for (int k = NUM_REQ - 1; k >= 0; k--) begin
			if (reqLine[k]) begin
				hitVec = VEC_TABLE[k*16 +: 16];
			end
		end
	end

	always_comb begin
		s_next = s_reg;
		wrEn = psel & penable & pwrite & s_reg.pready;
		setupRd = psel & ~penable & ~pwrite;

		// pins pass two flops before the edge detector looks at them
		s_next.pinSync1 = extPins;
		s_next.pinSync2 = s_reg.pinSync1;
		s_next.pinPrev = s_reg.pinSync2;

		// cpu clock strobe; the divider stands still while the oscillator is off
		divLast = s_reg.misc[MISC_SLOW_SEL] ? DIV_FAST - 3'h1 : DIV_SLOW - 3'h1;
		tick = (s_reg.mode != MODE_HALT) && (s_reg.divCnt == 3'h0);
		if (s_reg.mode == MODE_HALT) begin
			s_next.divCnt = 3'h0;
		end else if (s_reg.divCnt >= divLast) begin
			s_next.divCnt = 3'h0;
		end else begin
			s_next.divCnt = s_reg.divCnt + 3'h1;
		end
		s_next.cpuTick = tick;

		// APB: answer in the second access cycle, data latched at setup
		s_next.pready = psel & penable & ~s_reg.pready;
		s_next.pslverr = 1'b0;
		if (psel & penable & ~s_reg.pready) begin
			s_next.pslverr = !(paddr inside {ADDR_MISC, ADDR_EDGE, ADDR_STATUS, ADDR_VECTOR});
		end
		if (setupRd) begin
			unique case (paddr)
				ADDR_MISC: s_next.prdata = {24'h000000, s_reg.misc};
				ADDR_EDGE: s_next.prdata = {24'h000000, s_reg.edgeReg};
				ADDR_STATUS: s_next.prdata = {27'h0, s_reg.bootPending, s_reg.irqRequest,
					s_reg.iMask, s_reg.mode};
				ADDR_VECTOR: s_next.prdata = {16'h0000, s_reg.vectorAddr};
				default: s_next.prdata = 32'h00000000;
			endcase
		end

		// control bits; reserved bits 4..1 stay zero
		if (wrEn && paddr == ADDR_MISC) begin
			s_next.misc[MISC_PC2_EN] = pwdata[MISC_PC2_EN];
			s_next.misc[MISC_SLOW_SEL] = pwdata[MISC_SLOW_SEL];
			s_next.misc[MISC_DRV_SEL] = pwdata[MISC_DRV_SEL];
		end
		if (wrEn && paddr == ADDR_EDGE) begin
			s_next.edgeReg[EDGE_EN_TOP:0] = pwdata[EDGE_EN_TOP:0];
		end

		// flags: a write of zero clears, a new edge in the same cycle wins
		for (int k = 0; k < SRC_PC2; k++) begin
			s_next.edgeReg[EDGE_FLAG_TOP-k] = (s_reg.edgeReg[EDGE_FLAG_TOP-k] &
				~(wrEn && paddr == ADDR_EDGE && !pwdata[EDGE_FLAG_TOP-k])) | edgeSeen[k];
		end
		s_next.misc[MISC_PC2_FLAG] = (s_reg.misc[MISC_PC2_FLAG] &
			~(wrEn && paddr == ADDR_MISC && !pwdata[MISC_PC2_FLAG])) | edgeSeen[SRC_PC2];

		// converter outputs 1..4 follow the drive select, output 0 is always push-pull
		s_next.daOpenDrain = {{4{s_reg.misc[MISC_DRV_SEL]}}, 1'b0};

		// mask bit: the cpu takes a vector after stacking, return pops it clear
		if (cpuCmd.vectorFetch) begin
			s_next.iMask = 1'b1;
			s_next.bootPending = 1'b0;
		end else if (cpuCmd.returnFromIrq) begin
			s_next.iMask = 1'b0;
		end

		s_next.watchdogResetReq = 1'b0;
		restartDone = tick && (s_reg.restartCnt == 13'(RESTART_CYCLES - 1));
		unique case (s_reg.mode)
			MODE_RUN: begin
				if (cpuCmd.haltInstr && cpuCmd.watchdogEnabled) begin
					s_next.watchdogResetReq = 1'b1;
				end else if (cpuCmd.haltInstr) begin
					s_next.mode = MODE_HALT;
					s_next.iMask = 1'b0;
				end else if (cpuCmd.waitInstr) begin
					s_next.mode = MODE_WAIT;
					s_next.iMask = 1'b0;
				end
			end
			MODE_WAIT: begin
				// peripherals keep running; any enabled request ends the wait
				if (anyReq) begin
					s_next.mode = MODE_RUN;
				end
			end
			MODE_HALT: begin
				if (wakeHalt) begin
					s_next.mode = MODE_RESTART;
					s_next.restartCnt = 13'h0000;
				end
			end
			MODE_RESTART: begin
				if (restartDone) begin
					s_next.mode = MODE_RUN;
				end else if (tick) begin
					s_next.restartCnt = s_reg.restartCnt + 13'h0001;
				end
			end
		endcase

		s_next.cpuHold = (s_next.mode != MODE_RUN);
		s_next.oscEnable = (s_next.mode != MODE_HALT);
		// masked or disabled requests simply stay pending until served
		s_next.irqRequest = anyReq && !s_reg.iMask && s_reg.mode == MODE_RUN
			&& !cpuCmd.vectorFetch;
		if (s_reg.bootPending) begin
			s_next.vectorAddr = VEC_RESET;
		end else if (anyReq) begin
			s_next.vectorAddr = hitVec;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
			s_reg.mode <= MODE_RESTART;
			s_reg.iMask <= 1'b1;
			s_reg.bootPending <= 1'b1;
			s_reg.misc <= MISC_RESET;
			s_reg.edgeReg <= EDGE_RESET;
			s_reg.vectorAddr <= VEC_RESET;
			s_reg.cpuHold <= 1'b1;
			s_reg.oscEnable <= 1'b1;
			// rising source starts its chain high so a pin already high is not taken for an edge
			s_reg.pinSync1[SRC_RISE] <= 1'b1;
			s_reg.pinSync2[SRC_RISE] <= 1'b1;
			s_reg.pinPrev[SRC_RISE] <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	chk_slow_divide: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.cpuTick && !s_reg.misc[MISC_SLOW_SEL] && s_reg.mode != MODE_HALT && !cpuCmd.haltInstr
		|=> (!s_reg.cpuTick || s_reg.misc[MISC_SLOW_SEL] || s_reg.mode == MODE_RESTART) [*5])
		else $error("cpu strobe faster than divide by six");

	chk_fast_divide: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.cpuTick && s_reg.misc[MISC_SLOW_SEL] && $stable(s_reg.misc) && s_reg.mode == MODE_RUN
		&& !cpuCmd.haltInstr |=> !s_reg.cpuTick [*2])
		else $error("cpu strobe faster than divide by three");

	chk_wdg_halt: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.mode == MODE_RUN && cpuCmd.haltInstr && cpuCmd.watchdogEnabled
		|=> s_reg.watchdogResetReq && s_reg.oscEnable ##1 !s_reg.watchdogResetReq)
		else $error("halt with watchdog on did not give a reset pulse");

	chk_halt_entry: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.mode == MODE_RUN && cpuCmd.haltInstr && !cpuCmd.watchdogEnabled && !cpuCmd.vectorFetch
		|=> !s_reg.oscEnable && !s_reg.iMask && s_reg.cpuHold)
		else $error("halt entry did not stop oscillator and clear mask");

	chk_wait_entry: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.mode == MODE_RUN && cpuCmd.waitInstr && !cpuCmd.haltInstr && !cpuCmd.vectorFetch
		|=> s_reg.cpuHold && s_reg.oscEnable && !s_reg.iMask)
		else $error("wait entry wrong");

	chk_flag_kept: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.edgeReg[EDGE_FLAG_TOP] && !(psel && penable && pwrite && paddr == ADDR_EDGE)
		|=> s_reg.edgeReg[EDGE_FLAG_TOP])
		else $error("edge flag lost without a software clear");

	chk_pc2_edge: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.pinPrev[SRC_PC2] && !s_reg.pinSync2[SRC_PC2] |=> s_reg.misc[MISC_PC2_FLAG])
		else $error("falling edge on port C pin 2 not latched");

	chk_restart_len: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.mode == MODE_RESTART && s_next.mode == MODE_RUN
		|-> s_reg.restartCnt == 13'(RESTART_CYCLES - 1) && s_reg.cpuHold)
		else $error("restart delay length wrong");

	chk_mask_gate: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.irqRequest |-> $past(!s_reg.iMask) && $past(anyReq))
		else $error("request raised while masked or idle");

	chk_fetch_masks: assert property (@(posedge clock) disable iff (!nrst)
		cpuCmd.vectorFetch && !cpuCmd.waitInstr && !cpuCmd.haltInstr |=> s_reg.iMask)
		else $error("mask bit not set on vector fetch");

	chk_halt_still: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.mode == MODE_HALT && $past(s_reg.mode) == MODE_HALT |-> !s_reg.cpuTick && !s_reg.oscEnable)
		else $error("clock activity during halt");

	chk_wait_exit: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.mode == MODE_WAIT && anyReq |=> s_reg.mode == MODE_RUN && !s_reg.cpuHold)
		else $error("wait not left on a pending request");

	chk_boot_vector: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.bootPending |-> s_reg.vectorAddr == VEC_RESET)
		else $error("reset vector not offered while boot pending");

	chk_rise_latch: assert property (@(posedge clock) disable iff (!nrst)
		!s_reg.pinPrev[SRC_RISE] && s_reg.pinSync2[SRC_RISE] |=> s_reg.edgeReg[EDGE_FLAG_TOP-SRC_RISE])
		else $error("rising edge on source three not latched");

	chk_drive_open: assert property (@(posedge clock) disable iff (!nrst)
		s_reg.misc[MISC_DRV_SEL] |=> s_reg.daOpenDrain == 5'h1e)
		else $error("converter outputs not open drain");

	chk_drive_push: assert property (@(posedge clock) disable iff (!nrst)
		!s_reg.misc[MISC_DRV_SEL] |=> s_reg.daOpenDrain == 5'h00)
		else $error("converter outputs not push-pull");

	chk_prio_pick: assert property (@(posedge clock) disable iff (!nrst)
		reqLine[REQ_EXT3] && !reqLine[REQ_USB_RESUME] && !s_reg.bootPending
		|=> s_reg.vectorAddr == VEC_TABLE[REQ_EXT3*16 +: 16])
		else $error("source three not chosen first");
endmodule

// ---- core/iwp_pkg.sv ----
package iwp_pkg;
	// register byte offsets on the APB
	localparam logic [7:0] ADDR_MISC = 8'h00;
	localparam logic [7:0] ADDR_EDGE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_VECTOR = 8'h0c;

	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam logic [7:0] EDGE_RESET = 8'h00;

	// misc_control_reg fields
	localparam int MISC_PC2_FLAG = 7;
	localparam int MISC_PC2_EN = 6;
	localparam int MISC_SLOW_SEL = 5;
	localparam int MISC_DRV_SEL = 0;

	// edge_irq_reg: flag of source k (0..3) at bit EDGE_FLAG_TOP-k, enable at EDGE_EN_TOP-k; source 4 lives in misc
	localparam int EDGE_FLAG_TOP = 7;
	localparam int EDGE_EN_TOP = 3;

	localparam int NUM_EXT = 5;
	localparam int SRC_RISE = 3;
	localparam int SRC_PC2 = 4;

	localparam logic [2:0] DIV_SLOW = 3'h6;
	localparam logic [2:0] DIV_FAST = 3'h3;
	localparam int RESTART_CYCLES_DEF = 4096;

	// request slots, highest priority first
	localparam int NUM_REQ = 12;
	localparam int REQ_USB_RESUME = 0;
	localparam int REQ_EXT3 = 1;
	localparam int REQ_EXT2 = 2;
	localparam int REQ_EXT1 = 3;
	localparam int REQ_EXT0 = 4;
	localparam int REQ_EXT4 = 5;
	localparam int REQ_TIM_CAP = 6;
	localparam int REQ_TIM_CMP = 7;
	localparam int REQ_TIM_OVF = 8;
	localparam int REQ_I2C = 9;
	localparam int REQ_SCI = 10;
	localparam int REQ_USB = 11;

	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [NUM_REQ*16-1:0] VEC_TABLE = {
		16'hffe0, 16'hffe2, 16'hffe4, 16'hffe6, 16'hffe8, 16'hffea,
		16'hffee, 16'hfff0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hfffa};
	// slots that may end halt: end-of-suspend and the five edge sources
	localparam logic [NUM_REQ-1:0] HALT_WAKE = 12'h03f;

	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_WAIT = 2'b01,
		MODE_HALT = 2'b10,
		MODE_RESTART = 2'b11
	} iwp_mode_t;

	typedef struct packed {
		logic waitInstr;
		logic haltInstr;
		logic vectorFetch;
		logic returnFromIrq;
		logic watchdogEnabled;
	} iwp_cpu_cmd_t;

	typedef struct packed {
		logic usbEndSuspend;
		logic timerCapture;
		logic timerCompare;
		logic timerOverflow;
		logic i2cIrq;
		logic [4:0] sciFlags;
		logic [4:0] sciEnables;
		logic [7:0] usbFlags;
		logic [7:0] usbEnables;
	} iwp_per_req_t;

	typedef struct packed {
		iwp_mode_t mode;
		logic [2:0] divCnt;
		logic [12:0] restartCnt;
		logic iMask;
		logic bootPending;
		logic [7:0] misc;
		logic [7:0] edgeReg;
		logic [NUM_EXT-1:0] pinSync1;
		logic [NUM_EXT-1:0] pinSync2;
		logic [NUM_EXT-1:0] pinPrev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irqRequest;
		logic [15:0] vectorAddr;
		logic cpuHold;
		logic oscEnable;
		logic cpuTick;
		logic watchdogResetReq;
		logic [4:0] daOpenDrain;
	} iwp_state_t;
endpackage

// ---- sim/iwp_cpu_model.sv ----
`timescale 1ns/100ps
module iwp_cpu_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic ackEn,
	input wire logic irqRequest,
	input wire logic [15:0] vectorAddr,
	output logic vectorFetch,
	output logic [15:0] lastVec,
	output int nFetch
);
	// ackEn low stands for a core busy in a long instruction: the request must wait
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			vectorFetch <= 1'b0;
			lastVec <= 16'h0000;
			nFetch <= 0;
		end else begin
			// skip the cycle after a fetch, the raised mask is not visible yet
			vectorFetch <= irqRequest && ackEn && !vectorFetch;
			if (irqRequest && ackEn && !vectorFetch) begin
				lastVec <= vectorAddr;
				nFetch <= nFetch + 1;
			end
		end
	end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top import iwp_pkg::*;;
	localparam int RST = 4;
	logic clock, nrst, psel, penable, pwrite, ackEn, modelFetch, err;
	logic pready, pslverr, irqRequest, intMask, cpuHold, oscEnable, cpuTick, watchdogResetReq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] extPins, daOpenDrain;
	logic [15:0] vectorAddr, lastVec;
	logic [15:0] vecs [5] = '{16'hfff0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hffee};
	iwp_cpu_cmd_t cmdTb, cpuCmd;
	iwp_per_req_t perReq;
	int n_fail = 0, samples_checked = 0, cyc = 0, seen = 0, nFetch;
	assign cpuCmd = iwp_cpu_cmd_t'(cmdTb | {2'b00, modelFetch, 2'b00});
	iwp_ctrl #(.RESTART_CYCLES(RST)) uut (
		.clock(clock),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.extPins(extPins),
		.cpuCmd(cpuCmd),
		.perReq(perReq),
		.irqRequest(irqRequest),
		.vectorAddr(vectorAddr),
		.intMask(intMask),
		.cpuHold(cpuHold),
		.oscEnable(oscEnable),
		.cpuTick(cpuTick),
		.watchdogResetReq(watchdogResetReq),
		.daOpenDrain(daOpenDrain)
	);
	iwp_cpu_model cpu (
		.clock(clock),
		.nrst(nrst),
		.ackEn(ackEn),
		.irqRequest(irqRequest),
		.vectorAddr(vectorAddr),
		.vectorFetch(modelFetch),
		.lastVec(lastVec),
		.nFetch(nFetch)
	);
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;
	task conclude;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		samples_checked++;
		if (!ok) begin
			n_fail++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task give_up(input string m);
		n_fail++;
		$display("mismatch %0t timeout in %s", $time, m);
		conclude();
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) give_up("apb");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input int b);
		@(posedge clock);
		cmdTb[b] <= 1'b1;
		@(posedge clock);
		cmdTb[b] <= 1'b0;
		#1;
	endtask
	// one toggle there and back gives exactly one active edge for either polarity
	task pin(input int k);
		@(posedge clock);
		extPins[k] <= ~extPins[k];
		repeat (4) @(posedge clock);
		extPins[k] <= ~extPins[k];
		repeat (4) @(posedge clock);
	endtask
	task wait_vec(input logic [15:0] v);
		int i;
		i = 0;
		while (nFetch == seen && i < 300) begin
			@(posedge clock);
			i++;
		end
		if (i >= 300) give_up("fetch");
		seen = nFetch;
		chk(lastVec === v, "vector");
		@(posedge clock);
		#1;
		chk(intMask === 1'b1, "mask after fetch");
	endtask
	task wait_run(input int c0, input int slack);
		int i;
		i = 0;
		while (cpuHold !== 1'b0 && i < 1000) begin
			@(posedge clock);
			i++;
		end
		if (i >= 1000) give_up("restart");
		chk(cyc - c0 >= RST * 6 && cyc - c0 <= RST * 6 + slack, "restart length");
	endtask
	task tick_period(output int p);
		int i;
		repeat (8) @(posedge clock);
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (cpuTick !== 1'b1 && i < 20);
		p = 0;
		do begin
			@(posedge clock);
			p++;
		end while (cpuTick !== 1'b1 && p < 20);
		if (i >= 20 || p >= 20) give_up("tick");
	endtask
	task t_reset;
		#1;
		chk(intMask === 1'b1 && cpuHold === 1'b1 && vectorAddr === VEC_RESET, "reset out");
		apb(0, ADDR_MISC, 0);
		chk(rd === 32'(MISC_RESET) && err === 1'b0, "misc reset");
		apb(0, ADDR_EDGE, 0);
		chk(rd === 32'(EDGE_RESET), "edge reset");
		apb(0, 8'h10, 0);
		chk(rd === 32'h0 && err === 1'b1, "unmapped");
		wait_run(0, 14);
		chk(vectorAddr === VEC_RESET, "reset vector");
		pulse(2);
		pulse(1);
	endtask
	task t_misc;
		int p;
		apb(1, ADDR_MISC, 32'h21);
		apb(0, ADDR_MISC, 0);
		chk(rd === 32'h21 && daOpenDrain === 5'h1e, "drive select");
		tick_period(p);
		chk(p == 3, "divide by three");
		apb(1, ADDR_MISC, 0);
		tick_period(p);
		chk(p == 6 && daOpenDrain === 5'h00, "divide by six");
	endtask
	task t_edges;
		logic [31:0] en, fl;
		logic [7:0] a;
		for (int k = 0; k < 5; k++) begin
			a = (k == 4) ? ADDR_MISC : ADDR_EDGE;
			en = (k == 4) ? 32'h40 : 32'h08 >> k;
			fl = (k == 4) ? 32'h80 : 32'h80 >> k;
			apb(1, a, en);
			pin(k);
			wait_vec(vecs[k]);
			apb(0, a, 0);
			chk(rd === (en | fl), "flag set");
			apb(1, a, en | fl);
			apb(0, a, 0);
			chk(rd === (en | fl), "flag kept");
			apb(1, a, 0);
			apb(0, a, 0);
			chk(rd === 32'h0, "flag cleared");
			pulse(1);
		end
	endtask
	task t_prio;
		pin(0);
		pin(3);
		chk(irqRequest === 1'b0, "disabled stays quiet");
		apb(0, ADDR_EDGE, 0);
		chk(rd === 32'h90, "both pending");
		ackEn <= 1'b0;
		apb(1, ADDR_EDGE, 32'h99);
		repeat (4) @(posedge clock);
		chk(irqRequest === 1'b1, "request raised");
		ackEn <= 1'b1;
		wait_vec(16'hfff6);
		apb(0, ADDR_VECTOR, 0);
		chk(rd === 32'h0000fff6, "vector register");
		apb(1, ADDR_EDGE, 32'h89);
		pulse(1);
		wait_vec(16'hfff0);
		apb(1, ADDR_EDGE, 0);
		pulse(1);
	endtask
	task t_wait;
		pulse(4);
		chk(cpuHold === 1'b1 && intMask === 1'b0, "wait entry");
		repeat (3) @(posedge clock);
		perReq.timerOverflow <= 1'b1;
		perReq.usbFlags <= 8'h04;
		perReq.usbEnables <= 8'h04;
		perReq.sciFlags <= 5'h03;
		perReq.sciEnables <= 5'h02;
		wait_vec(16'hffe6);
		perReq.timerOverflow <= 1'b0;
		pulse(1);
		wait_vec(16'hffe2);
		perReq.sciFlags <= 5'h00;
		pulse(1);
		wait_vec(16'hffe0);
		perReq.usbFlags <= 8'h00;
		pulse(1);
	endtask
	task t_halt;
		int c0;
		cmdTb.watchdogEnabled <= 1'b1;
		pulse(3);
		chk(watchdogResetReq === 1'b1 && oscEnable === 1'b1 && cpuHold === 1'b0, "halt refused");
		cmdTb.watchdogEnabled <= 1'b0;
		apb(1, ADDR_EDGE, 32'h01);
		pulse(3);
		chk(oscEnable === 1'b0 && cpuHold === 1'b1 && intMask === 1'b0, "halt entry");
		repeat (20) @(posedge clock);
		chk(oscEnable === 1'b0 && cpuTick === 1'b0, "halted");
		apb(0, ADDR_STATUS, 0);
		chk(rd === 32'h00000002, "status in halt");
		c0 = cyc;
		pin(3);
		wait_run(c0, 14);
		wait_vec(16'hfff6);
		apb(1, ADDR_EDGE, 0);
		pulse(1);
	endtask
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		extPins = 5'h17;
		cmdTb = '0;
		perReq = '0;
		ackEn = 1'b1;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_misc();
		t_edges();
		t_prio();
		t_wait();
		t_halt();
		conclude();
	end
endmodule
